// File: verilog/cks_pkg.sv
// Package of constants and types for the system clock source selection block.
//----------------------------------------------------------------------------
// Function
// R1 - Config field 11, 10, 01 selects external clock high, medium, low power.
// R2 - After power-up or any reset, run from the config-selected clock source.
// R3 - Config field 00 makes the internal oscillator block the default source.
// R4 - Select bits cleared: system clock follows the config field, maybe external.
// R5 - Upper select bit set: enable internal oscillator and run from it.
// R6 - External mode clocks directly from the input pin with no start-up delay.
// R7 - Stopped external clock halts the block, state kept, resumes on restart.
// R8 - Internal source active releases the clock input pin for general I/O.
// R9 - Clock-out config bit gives output pin either clock output or general I/O.
// R10 - High-frequency oscillator feeds divider and mux; frequency select picks rate.
// R11 - Enable high-frequency oscillator for HF rate with config 00 or select 1x.
// R12 - Switch to high-frequency oscillator only after its start-up has completed.
// R13 - Read-only HF ready flag set while the HF oscillator runs.
// R14 - Read-only HF stable flag set only once HF oscillator is within 0.5%.
// R15 - Frequency select 000x with select 1x enables and uses the 31 kHz oscillator.
// R16 - Low-frequency oscillator is the time base of power-up and watchdog timers.
// R17 - Read-only LF ready flag set while the LF oscillator runs.
// R18 - Clock-out config bit 0 drives clock output on pin; 1 leaves pin as I/O.
// R19 - Frequency select resets to 0111 (500 kHz); 000x selects 31 kHz.
// R20 - Both select bits clear on every reset.
// R21 - Frequency change waits new oscillator start-up, then switches on falling edge.
// R22 - Ready and stable flags pass a two-flop synchroniser before software reads.
//----------------------------------------------------------------------------
package cks_pkg;

  //--------------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ   = 250;
  localparam int unsigned HF_WARM_NS     = 2000;
  localparam int unsigned HF_SETTLE_NS   = 1000;
  localparam int unsigned LF_WARM_NS     = 2000;
  localparam int unsigned HF_WARM_CYC    = (HF_WARM_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned HF_SETTLE_CYC  = (HF_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned LF_WARM_CYC    = (LF_WARM_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned HF_HALF_DIV    = 8;
  localparam int unsigned LF_HALF_DIV    = 4032;
  localparam int unsigned PS_W           = 9;

  //--------------------------------------------------------------------------
  // Register map and fields
  //--------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STAT      = 12'h004;
  localparam logic [11:0] ADDR_CFG       = 12'h008;
  localparam int unsigned FSEL_LSB       = 3;
  localparam int unsigned FSEL_MSB       = 6;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEL_MSB        = 1;
  localparam int unsigned STAT_HFR       = 4;
  localparam int unsigned STAT_LFR       = 1;
  localparam int unsigned STAT_HFS       = 0;
  localparam int unsigned CFG_SRC_LSB    = 0;
  localparam int unsigned CFG_SRC_MSB    = 1;
  localparam int unsigned CFG_CLOCK_OUTPUT_PIN_BIT = 2;
  localparam int unsigned CFG_ACT_LSB    = 4;
  localparam int unsigned CFG_ACT_MSB    = 5;
  localparam logic [3:0]  FSEL_RST       = 4'h7;
  localparam logic [1:0]  SEL_RST        = 2'h0;

  //--------------------------------------------------------------------------
  // Encodings
  //--------------------------------------------------------------------------
  localparam logic [1:0]  CFG_INTERNAL   = 2'h0;
  localparam logic [1:0]  CFG_EXT_LOW    = 2'h1;
  localparam logic [1:0]  CFG_EXT_MED    = 2'h2;
  localparam logic [1:0]  CFG_EXT_HIGH   = 2'h3;

  typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_HF, SRC_LF} cks_src_t;

  typedef struct packed {
    logic hf_ready;
    logic lf_ready;
    logic hf_stable;
  } cks_osc_flags_t;

endpackage : cks_pkg

// File: verilog/cks_clock_select.sv
// System clock source selection with internal oscillator models and APB registers.
`timescale 1ns/100ps
module cks_clock_select
  import cks_pkg::*;
#(
  parameter int unsigned HF_DIV   = HF_HALF_DIV,
  parameter int unsigned LF_DIV   = LF_HALF_DIV,
  parameter int unsigned HF_WARM  = HF_WARM_CYC,
  parameter int unsigned HF_SETL  = HF_SETTLE_CYC,
  parameter int unsigned LF_WARM  = LF_WARM_CYC
)(
  input  wire logic        clk,                 // System clock, 250 MHz.
  input  wire logic        rst_n,               // Asynchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB enable.
  input  wire logic        pwrite,              // APB write.
  input  wire logic [11:0] paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  input  wire logic [1:0]  clock_source_config, // Non-volatile source field.
  input  wire logic        clock_out_enable,    // Non-volatile clock-out bit, 0 = on.
  input  wire logic        clock_input_pin,     // External clock level.
  input  wire logic        timer_base_request,  // Timers need the LF time base.
  output logic [31:0]      prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error on unmapped address.
  output logic             sys_tick,            // System clock rising-edge enable.
  output logic             clock_output_o,      // Clock output pin level.
  output logic             clock_output_oe,     // Clock output pin enable.
  output logic             clock_input_pin_released,      // Input pin free for general I/O.
  output logic             timer_tick,          // LF time base for timers.
  output logic             hf_osc_ready,        // Synchronised HF ready flag.
  output logic             hf_osc_stable,       // Synchronised HF stable flag.
  output logic             lf_osc_ready         // Synchronised LF ready flag.
);

  //--------------------------------------------------------------------------
  // Parameter checks
  //--------------------------------------------------------------------------
  if (HF_DIV < 2 || LF_DIV < 2 || HF_WARM < 1 || HF_SETL < 1 || LF_WARM < 1)
  begin : g_bad_param
    $error("cks_clock_select: divider or start-up count too small");
  end

  localparam int unsigned HD_W = $clog2(HF_DIV);
  localparam int unsigned LD_W = $clog2(LF_DIV);
  localparam int unsigned WC_W = $clog2(HF_WARM + HF_SETL + LF_WARM + 1);

  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_WAIT_READY, ST_WAIT_FALL} cks_state_t;

  //--------------------------------------------------------------------------
  // Decoding functions
  //--------------------------------------------------------------------------
  function automatic logic [3:0] fsel_shift(input logic [3:0] f);
    logic [3:0] k;
    k = 4'h0;
    unique casez (f)
      4'b1111: k = 4'h0;
      4'b1110: k = 4'h1;
      4'b1101: k = 4'h2;
      4'b1100: k = 4'h3;
      4'b1011: k = 4'h4;
      4'b1010: k = 4'h5;
      4'b1001: k = 4'h6;
      4'b1000: k = 4'h7;
      4'b0111: k = 4'h5;
      4'b0110: k = 4'h6;
      4'b0101: k = 4'h7;
      4'b0100: k = 4'h8;
      4'b001?: k = 4'h9;
      4'b000?: k = 4'h0;
    endcase
    return k;
  endfunction : fsel_shift

  function automatic logic fsel_is_lf(input logic [3:0] f);
    return f[3:1] == 3'h0;
  endfunction : fsel_is_lf

  function automatic logic [PS_W-1:0] ps_mask(input logic [3:0] k);
    logic [PS_W:0] one;
    one = {{PS_W{1'b0}}, 1'b1};
    return PS_W'((one << k) - one);
  endfunction : ps_mask

  //--------------------------------------------------------------------------
  // Registers and state
  //--------------------------------------------------------------------------
  logic [3:0]       fsel_reg;
  logic [1:0]       sel_reg;
  logic [1:0]       cfg_src_reg;
  logic             cfg_clock_output_pin_reg;
  cks_state_t       state_reg;
  cks_src_t         cur_src_reg;
  logic [3:0]       cur_k_reg;
  logic             cur_lvl_reg;
  logic             pin_q_reg;
  logic             hf_ready_reg;
  logic             hf_stable_reg;
  logic             lf_ready_reg;
  logic [WC_W-1:0]  hf_cnt_reg;
  logic [WC_W-1:0]  lf_cnt_reg;
  logic [HD_W-1:0]  hf_div_reg;
  logic [LD_W-1:0]  lf_div_reg;
  logic [PS_W-1:0]  ps_cnt_reg;
  cks_osc_flags_t   flags_meta_reg;
  cks_osc_flags_t   flags_sync_reg;

  logic             apb_access;
  logic             apb_commit;
  logic             internal_sel;
  cks_src_t         target_src;
  logic [3:0]       target_k;
  logic             hf_en;
  logic             lf_en;
  logic             hf_tick;
  logic             lf_tick;
  logic             ps_tick;
  logic             src_edge;
  logic             src_rise;
  logic             src_fall;
  logic             target_ready;
  logic             need_switch;

  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready;

  //--------------------------------------------------------------------------
  // Source and oscillator requests
  //--------------------------------------------------------------------------
  always_comb
  begin
    internal_sel = sel_reg[1] || (cfg_src_reg == CFG_INTERNAL);      // see R3 see R4 see R5
    target_k     = fsel_shift(fsel_reg);                             // see R10
    if (!internal_sel)
    begin
      target_src = SRC_EXT;                                          // see R1 see R4
    end
    else if (fsel_is_lf(fsel_reg))
    begin
      target_src = SRC_LF;                                           // see R15
    end
    else
    begin
      target_src = SRC_HF;
    end
    hf_en = (internal_sel && !fsel_is_lf(fsel_reg)) || (cur_src_reg == SRC_HF); // see R11
    lf_en = (internal_sel && fsel_is_lf(fsel_reg)) || (cur_src_reg == SRC_LF)
            || timer_base_request;                                   // see R15 see R16
  end

  //--------------------------------------------------------------------------
  // Oscillator start-up, ready and stable
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hf_cnt_reg    <= '0;
      hf_ready_reg  <= 1'b0;
      hf_stable_reg <= 1'b0;
    end
    else if (!hf_en)
    begin
      hf_cnt_reg    <= '0;
      hf_ready_reg  <= 1'b0;                                         // see R13
      hf_stable_reg <= 1'b0;
    end
    else
    begin
      if (hf_cnt_reg != WC_W'(HF_WARM + HF_SETL))
      begin
        hf_cnt_reg <= hf_cnt_reg + 1'b1;
      end
      if (hf_cnt_reg == WC_W'(HF_WARM - 1))
      begin
        hf_ready_reg <= 1'b1;                                        // see R12 see R13
      end
      if (hf_cnt_reg == WC_W'(HF_WARM + HF_SETL - 1))
      begin
        hf_stable_reg <= 1'b1;                                       // see R14
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_cnt_reg   <= '0;
      lf_ready_reg <= 1'b0;
    end
    else if (!lf_en)
    begin
      lf_cnt_reg   <= '0;
      lf_ready_reg <= 1'b0;                                          // see R17
    end
    else if (lf_cnt_reg == WC_W'(LF_WARM - 1))
    begin
      lf_ready_reg <= 1'b1;                                          // see R17
    end
    else
    begin
      lf_cnt_reg <= lf_cnt_reg + 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // Oscillator half-period dividers and postscaler
  //--------------------------------------------------------------------------
  assign hf_tick = hf_ready_reg && (hf_div_reg == HD_W'(HF_DIV - 1));
  assign lf_tick = lf_ready_reg && (lf_div_reg == LD_W'(LF_DIV - 1));
  assign ps_tick = hf_tick && ((ps_cnt_reg & ps_mask(cur_k_reg)) == ps_mask(cur_k_reg));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hf_div_reg <= '0;
      lf_div_reg <= '0;
      ps_cnt_reg <= '0;
    end
    else
    begin
      hf_div_reg <= (!hf_ready_reg || hf_tick) ? '0 : hf_div_reg + 1'b1;
      lf_div_reg <= (!lf_ready_reg || lf_tick) ? '0 : lf_div_reg + 1'b1;
      if (hf_tick)
      begin
        ps_cnt_reg <= ps_cnt_reg + 1'b1;                             // see R10
      end
    end
  end

  //--------------------------------------------------------------------------
  // Current clock edges
  //--------------------------------------------------------------------------
  always_comb
  begin
    unique case (cur_src_reg)
      SRC_EXT:  src_edge = clock_input_pin != pin_q_reg;             // see R6 see R7
      SRC_HF:   src_edge = ps_tick;
      SRC_LF:   src_edge = lf_tick;
      SRC_NONE: src_edge = 1'b0;
    endcase
    src_rise = src_edge && !cur_lvl_reg;
    src_fall = src_edge && cur_lvl_reg;
    unique case (target_src)
      SRC_EXT:  target_ready = 1'b1;                                 // see R6
      SRC_HF:   target_ready = hf_ready_reg;                         // see R12
      SRC_LF:   target_ready = lf_ready_reg;
      SRC_NONE: target_ready = 1'b0;
    endcase
    need_switch = (target_src != cur_src_reg)
                  || ((target_src == SRC_HF) && (target_k != cur_k_reg));
  end

  //--------------------------------------------------------------------------
  // Clock switch sequencer
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= ST_BOOT;
      cur_src_reg    <= SRC_NONE;
      cur_k_reg      <= 4'h0;
      cur_lvl_reg    <= 1'b0;
      cfg_src_reg    <= CFG_INTERNAL;
      cfg_clock_output_pin_reg <= 1'b1;
    end
    else
    begin
      if (src_edge)
      begin
        cur_lvl_reg <= !cur_lvl_reg;
      end
      unique case (state_reg)
        ST_BOOT:
        begin
          cfg_src_reg    <= clock_source_config;                     // see R2
          cfg_clock_output_pin_reg <= clock_out_enable;
          state_reg      <= ST_RUN;
        end
        ST_RUN:
        begin
          if (need_switch)
          begin
            state_reg <= ST_WAIT_READY;
          end
        end
        ST_WAIT_READY:
        begin
          if (!need_switch)
          begin
            state_reg <= ST_RUN;
          end
          else if (target_ready && cur_src_reg == SRC_NONE)
          begin
            cur_src_reg <= target_src;                               // see R6 see R12
            cur_k_reg   <= target_k;
            cur_lvl_reg <= (target_src == SRC_EXT) ? clock_input_pin : 1'b0;
            state_reg   <= ST_RUN;
          end
          else if (target_ready)
          begin
            state_reg <= ST_WAIT_FALL;                               // see R21
          end
        end
        ST_WAIT_FALL:
        begin
          if (!need_switch)
          begin
            state_reg <= ST_RUN;
          end
          else if (!target_ready)
          begin
            state_reg <= ST_WAIT_READY;
          end
          else if (src_fall)
          begin
            cur_src_reg <= target_src;                               // see R21
            cur_k_reg   <= target_k;
            cur_lvl_reg <= (target_src == SRC_EXT) ? clock_input_pin : 1'b0;
            state_reg   <= ST_RUN;
          end
        end
      endcase
    end
  end

  //--------------------------------------------------------------------------
  // Clock outputs and pin ownership
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q_reg       <= 1'b0;
      sys_tick        <= 1'b0;
      timer_tick      <= 1'b0;
      clock_output_o  <= 1'b0;
      clock_output_oe <= 1'b0;
      clock_input_pin_released  <= 1'b0;
    end
    else
    begin
      pin_q_reg       <= clock_input_pin;
      sys_tick        <= src_rise;                                   // see R7
      timer_tick      <= lf_tick;                                    // see R16
      clock_output_o  <= cur_lvl_reg;
      clock_output_oe <= (state_reg != ST_BOOT) && !cfg_clock_output_pin_reg;  // see R9 see R18
      clock_input_pin_released  <= (cur_src_reg == SRC_HF) || (cur_src_reg == SRC_LF); // see R8
    end
  end

  //--------------------------------------------------------------------------
  // Flag synchroniser
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_meta_reg <= '0;
      flags_sync_reg <= '0;
    end
    else
    begin
      flags_meta_reg <= '{hf_ready: hf_ready_reg, lf_ready: lf_ready_reg,
                          hf_stable: hf_stable_reg};                 // see R22
      flags_sync_reg <= flags_meta_reg;
    end
  end

  assign hf_osc_ready  = flags_sync_reg.hf_ready;
  assign hf_osc_stable = flags_sync_reg.hf_stable;
  assign lf_osc_ready  = flags_sync_reg.lf_ready;

  //--------------------------------------------------------------------------
  // APB slave, one wait state
  //--------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsel_reg <= FSEL_RST;                                          // see R19
      sel_reg  <= SEL_RST;                                           // see R20
    end
    else if (apb_commit && pwrite && paddr == ADDR_CTRL)
    begin
      fsel_reg <= pwdata[FSEL_MSB:FSEL_LSB];
      sel_reg  <= pwdata[SEL_MSB:SEL_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready
                 && !(paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_CFG);
      prdata  <= '0;
      if (apb_access && !pready && !pwrite)
      begin
        unique case (paddr)
          ADDR_CTRL:
          begin
            prdata[FSEL_MSB:FSEL_LSB] <= fsel_reg;
            prdata[SEL_MSB:SEL_LSB]   <= sel_reg;
          end
          ADDR_STAT:
          begin
            prdata[STAT_HFR] <= flags_sync_reg.hf_ready;             // see R13 see R22
            prdata[STAT_LFR] <= flags_sync_reg.lf_ready;             // see R17
            prdata[STAT_HFS] <= flags_sync_reg.hf_stable;            // see R14
          end
          ADDR_CFG:
          begin
            prdata[CFG_SRC_MSB:CFG_SRC_LSB] <= cfg_src_reg;
            prdata[CFG_CLOCK_OUTPUT_PIN_BIT]          <= cfg_clock_output_pin_reg;
            prdata[CFG_ACT_MSB:CFG_ACT_LSB] <= cur_src_reg;
          end
          default:
          begin
            prdata <= '0;
          end
        endcase
      end
    end
  end

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  a_sel_reset_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R20
    (state_reg == ST_BOOT) |-> (sel_reg == SEL_RST && fsel_reg == FSEL_RST))
    else $error("select bits not cleared after reset");

  a_ext_no_delay: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    (state_reg == ST_BOOT && clock_source_config != CFG_INTERNAL) |-> ##3 (cur_src_reg == SRC_EXT))
    else $error("external clock not taken three cycles after boot");

  a_boot_internal: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    (state_reg == ST_BOOT && clock_source_config == CFG_INTERNAL) |=> ##1 hf_en)
    else $error("internal oscillator not requested after boot");

  a_hf_warm_wait: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    $rose(hf_ready_reg) |-> $past(hf_cnt_reg) == WC_W'(HF_WARM - 1))
    else $error("HF ready not after warm-up count");

  a_hf_on_source: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    (cur_src_reg == SRC_HF) |-> hf_ready_reg)
    else $error("running from HF oscillator that is not ready");

  a_stable_needs_ready: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    hf_stable_reg |-> (hf_ready_reg && $past(hf_ready_reg)))
    else $error("HF stable without HF ready");

  a_lf_ready_en: assert property (@(posedge clk) disable iff (!rst_n) // see R17
    !lf_en |=> !lf_ready_reg)
    else $error("LF ready while LF oscillator disabled");

  a_switch_on_fall: assert property (@(posedge clk) disable iff (!rst_n) // see R21
    (cur_src_reg != $past(cur_src_reg) && $past(cur_src_reg) != SRC_NONE) |-> $past(src_fall))
    else $error("clock switch not on a falling edge");

  a_ext_static_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    (cur_src_reg == SRC_EXT && clock_input_pin == pin_q_reg) |=> !sys_tick)
    else $error("system tick without external clock edge");

  a_pin_release: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    (cur_src_reg == SRC_LF) |=> clock_input_pin_released)
    else $error("input pin not released on internal source");

  a_status_sync: assert property (@(posedge clk) disable iff (!rst_n) // see R22
    $rose(hf_ready_reg) |-> ##2 hf_osc_ready)
    else $error("HF ready flag not visible two cycles later");

endmodule : cks_clock_select

// File: testbench/cks_ext_clk.sv
// External clock generator model driving the clock input pin.
`timescale 1ns/100ps
module cks_ext_clk (
  input  wire logic clk, // System clock.
  input  wire logic run, // Clock runs while high.
  output logic      pin  // External clock level.
);
  logic [1:0] cnt = 2'h0;
  initial pin = 1'b0;
  // A stopped clock stands still low, as a halted generator would.
  always @(posedge clk)
  begin
    cnt <= cnt + 2'h1;
    if (!run)
      pin <= 1'b0;
    else if (cnt == 2'h3)
      pin <= ~pin;
  end
endmodule : cks_ext_clk

// File: testbench/tb_cks_clock_select.sv
// Self-checking testbench for the system clock source selection block.
`timescale 1ns/100ps
module tb_cks_clock_select
  import cks_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, run = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, tick, co, coe, rel, ttick, hfr, hfs, lfr, pin, e;
  logic [1:0] cfg_in = 2'h3;
  logic cko_in = 0, tbr_in = 1;
  int err_total = 0, n_compared = 0;
  always #2 clk = ~clk;
  cks_ext_clk u_gen (.clk(clk), .run(run), .pin(pin));
  cks_clock_select #(.HF_DIV(2), .LF_DIV(4), .HF_WARM(4), .HF_SETL(3), .LF_WARM(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .clock_source_config(cfg_in), .clock_out_enable(cko_in),
    .clock_input_pin(pin), .timer_base_request(tbr_in), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_tick(tick), .clock_output_o(co), .clock_output_oe(coe),
    .clock_input_pin_released(rel), .timer_tick(ttick), .hf_osc_ready(hfr),
    .hf_osc_stable(hfs), .lf_osc_ready(lfr));
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      report_and_stop();
    end
  endtask : apb
  task automatic wait_src(input logic [1:0] s);
    for (int n = 0; n < 100 && q[5:4] !== s; n++)
      apb(1'b0, ADDR_CFG, 32'h0);
    chk(q[5:4], s, "active source");
  endtask : wait_src
  task automatic t_reset;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h38, "ctrl reset");
    wait_src(2'h1);
    chk(q, 32'h13, "cfg after boot");
    chk(coe, 1'b1, "clock out on");
    chk(rel, 1'b0, "pin in use");
    $display("test reset done");
  endtask : t_reset
  task automatic t_unmapped;
    apb(1'b0, 12'h00c, 32'h0);
    chk({q[0], e}, 2'h1, "unmapped read");
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_switch(input logic [31:0] c, input logic [1:0] s, input logic r,
                          input logic [31:0] st);
    apb(1'b1, ADDR_CTRL, c);
    q = 32'h0;
    wait_src(s);
    chk(rel, r, "pin release");
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(q, st, "status register");
    if (s == 2'h2)
      chk({hfr, hfs}, 2'h3, "hf flags");
    if (s == 2'h3)
      chk(lfr, 1'b1, "lf ready");
    $display("test switch %0d done", s);
  endtask : t_switch
  task automatic t_stop;
    int nt, nb;
    run <= 1'b0;
    repeat (20) @(posedge clk);
    nt = 0;
    nb = 0;
    repeat (60)
    begin
      @(negedge clk);
      nt += int'(tick === 1'b1);
      nb += int'(ttick === 1'b1);
    end
    chk(nt, 0, "halted ticks");
    chk(co, 1'b0, "halted level");
    chk(nb > 0, 1'b1, "timer base");
    run <= 1'b1;
    nt = 0;
    repeat (60)
    begin
      @(negedge clk);
      nt += int'(tick === 1'b1);
    end
    chk(nt > 0, 1'b1, "resumed ticks");
    $display("test stop done");
  endtask : t_stop
  task automatic t_reboot(input logic [1:0] c, input logic o, input logic [1:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg_in <= c;
    cko_in <= o;
    tbr_in <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    q = 32'h0;
    wait_src(s);
    chk(q, {26'h0, s, 1'b0, o, c}, "cfg after reset");
    chk({coe, rel}, {!o, s != 2'h1}, "pins after reset");
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(q, {27'h0, s == 2'h2, 3'h0, s == 2'h2}, "status after reset");
    $display("test reboot %0d done", c);
  endtask : t_reboot
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_unmapped();
    t_switch(32'h02, 2'h3, 1'b1, 32'h02);
    t_switch(32'h7a, 2'h2, 1'b1, 32'h13);
    t_switch(32'h78, 2'h1, 1'b0, 32'h02);
    t_stop();
    t_reboot(2'h0, 1'b1, 2'h2);
    t_reboot(2'h2, 1'b0, 2'h1);
    report_and_stop();
  end
endmodule : tb_cks_clock_select
